// *** core/cadc_pkg.sv ***
// Constants and types shared by the configurable mixed-signal port control
package cadc_pkg;

  localparam int PTR_W = 8;
  localparam int DATA_W = 16;
  localparam int CODE_W = 12;
  localparam int NCH = 8;
  localparam int CH_W = 4;
  localparam int CNT_W = 10;

  // Operation type in the upper half of the command pointer
  localparam logic [3:0] MODE_CFG = 4'h0;
  localparam logic [3:0] MODE_DAC_WR = 4'h1;
  localparam logic [3:0] MODE_ADC_RB = 4'h4;
  localparam logic [3:0] MODE_DAC_RB = 4'h5;
  localparam logic [3:0] MODE_GPIO_RB = 4'h6;
  localparam logic [3:0] MODE_REG_RB = 4'h7;

  // Control register index in the lower half of the pointer
  localparam logic [3:0] REG_NOP = 4'h0;
  localparam logic [3:0] REG_ADC_SEQ = 4'h2;
  localparam logic [3:0] REG_GP_CTRL = 4'h3;
  localparam logic [3:0] REG_ADC_CFG = 4'h4;
  localparam logic [3:0] REG_DAC_CFG = 4'h5;
  localparam logic [3:0] REG_PULLDN = 4'h6;
  localparam logic [3:0] REG_DEFER_LOAD = 4'h7;
  localparam logic [3:0] REG_GPIO_OCFG = 4'h8;
  localparam logic [3:0] REG_GPIO_DATA = 4'h9;
  localparam logic [3:0] REG_GPIO_ICFG = 4'hA;
  localparam logic [3:0] REG_PWR_REF = 4'hB;
  localparam logic [3:0] REG_SW_RESET = 4'hF;

  localparam logic [15:0] SW_RESET_KEY = 16'h0DAC;
  localparam logic [15:0] REG_DEFAULT = 16'h0000;
  localparam logic [15:0] PULLDN_DEFAULT = 16'h00FF;

  localparam int GP_DAC_RANGE_BIT = 4;
  localparam int GP_ADC_RANGE_BIT = 5;
  localparam int GP_LOCK_BIT = 7;
  localparam int GP_ADC_BUF_BIT = 9;
  localparam int SEQ_TEMP_BIT = 8;
  localparam int PWR_REF_BIT = 9;

  localparam logic [1:0] LOAD_IMMEDIATE = 2'h0;
  localparam logic [1:0] LOAD_HOLD = 2'h1;
  localparam logic [1:0] LOAD_TRANSFER = 2'h2;

  localparam logic [3:0] TEMP_CH = 4'h8;
  localparam logic [3:0] ACK_BIT_IDX = 4'h8;

  // Timing, figures as printed and the cycle counts derived from them
  localparam int CLK_NS = 40;
  localparam int TRACK_NS = 500;
  localparam int CONV_NS = 2000;
  localparam int TEMP_BUF_NS = 5000;
  localparam int TEMP_UNBUF_NS = 20000;
  localparam int RESET_US = 250;
  localparam int TRACK_CYC = (TRACK_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_CYC = CONV_NS / CLK_NS;
  localparam int TEMP_BUF_CYC = TEMP_BUF_NS / CLK_NS;
  localparam int TEMP_UNBUF_CYC = TEMP_UNBUF_NS / CLK_NS;
  localparam int RESET_CYC = RESET_US * 1000 / CLK_NS;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_TRACK = 2'b01,
    SEQ_CONV = 2'b10
  } cadc_seq_state_t;

endpackage

// *** core/cadc_port_ctrl.sv ***
// Control logic for an eight-pin configurable DAC, ADC and GPIO port
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps

module cadc_port_ctrl #(
  parameter logic [6:0] SLAVE_ADDR = 7'h10,
  parameter int RESET_HOLD_CYC = cadc_pkg::RESET_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [7:0] configurable_pin_in,
  output logic [7:0] configurable_pin_out,
  output logic [7:0] configurable_pin_oe,
  output logic [7:0] pulldown_en,
  output logic [7:0] dac_out_en,
  output logic [95:0] dac_code_flat,
  output logic dac_gain2,
  output logic [7:0] adc_in_en,
  output logic adc_gain2,
  output logic adc_buf_en,
  output logic ref_en,
  output logic [3:0] adc_mux_sel,
  output logic adc_track,
  output logic adc_convert,
  input wire logic [11:0] adc_code,
  output logic reset_busy
);

  localparam logic [9:0] TRACK_N = 10'(cadc_pkg::TRACK_CYC);
  localparam logic [9:0] CONV_N = 10'(cadc_pkg::CONV_CYC);
  localparam logic [9:0] TEMP_BUF_N = 10'(cadc_pkg::TEMP_BUF_CYC);
  localparam logic [9:0] TEMP_UNBUF_N = 10'(cadc_pkg::TEMP_UNBUF_CYC);
  localparam logic [12:0] RESET_N_CYC = 13'(RESET_HOLD_CYC);

  // Lowest set bit of mask at or after 'from', wrapping; {found, index}
  function automatic logic [4:0] next_ch(input logic [8:0] mask,
                                         input logic [3:0] from);
    logic [4:0] res;
    int idx;
    res = 5'h00;
    for (int i = 8; i >= 0; i--) begin
      idx = (int'(from) + i) % 9;
      if (mask[idx]) begin
        res = {1'b1, 4'(idx)};
      end
    end
    return res;
  endfunction

  // Command decode
  wire [3:0] op_mode = reg_addr[7:4];
  wire [3:0] op_idx = reg_addr[3:0];
  wire cfg_wr = reg_wr && (op_mode == cadc_pkg::MODE_CFG);
  wire dac_wr = reg_wr && (op_mode == cadc_pkg::MODE_DAC_WR)
                && !op_idx[3];
  wire sw_reset_wr = cfg_wr && (op_idx == cadc_pkg::REG_SW_RESET)
                     && (reg_wdata == cadc_pkg::SW_RESET_KEY);

  logic [15:0] seq_reg, gp_reg, adc_cfg_reg, dac_cfg_reg, pulldn_reg;
  logic [15:0] load_mode_reg, gpio_ocfg_reg, gpio_data_reg;
  logic [15:0] gpio_icfg_reg, pwr_reg;
  logic soft_rst_reg;
  logic [12:0] busy_cnt_reg;

  wire cfg_locked = gp_reg[cadc_pkg::GP_LOCK_BIT];
  wire pin_cfg_ok = !cfg_locked;
  wire wr_seq = cfg_wr && (op_idx == cadc_pkg::REG_ADC_SEQ);
  wire wr_gp = cfg_wr && (op_idx == cadc_pkg::REG_GP_CTRL);
  wire wr_adc_cfg = cfg_wr && (op_idx == cadc_pkg::REG_ADC_CFG)
                    && pin_cfg_ok;
  wire wr_dac_cfg = cfg_wr && (op_idx == cadc_pkg::REG_DAC_CFG)
                    && pin_cfg_ok;
  wire wr_pulldn = cfg_wr && (op_idx == cadc_pkg::REG_PULLDN)
                   && pin_cfg_ok;
  wire wr_load = cfg_wr && (op_idx == cadc_pkg::REG_DEFER_LOAD);
  wire wr_ocfg = cfg_wr && (op_idx == cadc_pkg::REG_GPIO_OCFG)
                 && pin_cfg_ok;
  wire wr_gdata = cfg_wr && (op_idx == cadc_pkg::REG_GPIO_DATA);
  wire wr_icfg = cfg_wr && (op_idx == cadc_pkg::REG_GPIO_ICFG)
                 && pin_cfg_ok;
  wire wr_pwr = cfg_wr && (op_idx == cadc_pkg::REG_PWR_REF);

  // Software reset lands one cycle after its write; the pin reset acts at once
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= sw_reset_wr;
    end
  end

  // Configuration registers; both resets give the same defaults
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_reg <= cadc_pkg::REG_DEFAULT;
      gp_reg <= cadc_pkg::REG_DEFAULT;
      adc_cfg_reg <= cadc_pkg::REG_DEFAULT;
      dac_cfg_reg <= cadc_pkg::REG_DEFAULT;
      pulldn_reg <= cadc_pkg::PULLDN_DEFAULT;
      load_mode_reg <= cadc_pkg::REG_DEFAULT;
      gpio_ocfg_reg <= cadc_pkg::REG_DEFAULT;
      gpio_data_reg <= cadc_pkg::REG_DEFAULT;
      gpio_icfg_reg <= cadc_pkg::REG_DEFAULT;
      pwr_reg <= cadc_pkg::REG_DEFAULT;
    end else if (soft_rst_reg) begin
      seq_reg <= cadc_pkg::REG_DEFAULT;
      gp_reg <= cadc_pkg::REG_DEFAULT;
      adc_cfg_reg <= cadc_pkg::REG_DEFAULT;
      dac_cfg_reg <= cadc_pkg::REG_DEFAULT;
      pulldn_reg <= cadc_pkg::PULLDN_DEFAULT;
      load_mode_reg <= cadc_pkg::REG_DEFAULT;
      gpio_ocfg_reg <= cadc_pkg::REG_DEFAULT;
      gpio_data_reg <= cadc_pkg::REG_DEFAULT;
      gpio_icfg_reg <= cadc_pkg::REG_DEFAULT;
      pwr_reg <= cadc_pkg::REG_DEFAULT;
    end else begin
      if (wr_seq) seq_reg <= reg_wdata;
      if (wr_gp) gp_reg <= reg_wdata;
      if (wr_adc_cfg) adc_cfg_reg <= reg_wdata;
      if (wr_dac_cfg) dac_cfg_reg <= reg_wdata;
      if (wr_pulldn) pulldn_reg <= reg_wdata;
      if (wr_load) load_mode_reg <= reg_wdata;
      if (wr_ocfg) gpio_ocfg_reg <= reg_wdata;
      if (wr_gdata) gpio_data_reg <= reg_wdata;
      if (wr_icfg) gpio_icfg_reg <= reg_wdata;
      if (wr_pwr) pwr_reg <= reg_wdata;
    end
  end

  // Busy window the host must respect after either reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_cnt_reg <= RESET_N_CYC;
    end else if (soft_rst_reg) begin
      busy_cnt_reg <= RESET_N_CYC;
    end else if (busy_cnt_reg != 13'h0000) begin
      busy_cnt_reg <= busy_cnt_reg - 13'h0001;
    end
  end
  assign reset_busy = (busy_cnt_reg != 13'h0000);

  // DAC input and output registers
  logic [11:0] dac_in_reg [cadc_pkg::NCH];
  logic [11:0] dac_out_reg [cadc_pkg::NCH];
  wire [2:0] dac_ch = op_idx[2:0];
  wire [1:0] load_mode = load_mode_reg[1:0];
  wire load_now = dac_wr && (load_mode == cadc_pkg::LOAD_IMMEDIATE);
  wire load_all = wr_load
                  && (reg_wdata[1:0] == cadc_pkg::LOAD_TRANSFER);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < cadc_pkg::NCH; i++) begin
        dac_in_reg[i] <= 12'h000;
        dac_out_reg[i] <= 12'h000;
      end
    end else if (soft_rst_reg) begin
      for (int i = 0; i < cadc_pkg::NCH; i++) begin
        dac_in_reg[i] <= 12'h000;
        dac_out_reg[i] <= 12'h000;
      end
    end else begin
      if (dac_wr) dac_in_reg[dac_ch] <= reg_wdata[11:0];
      if (load_all) begin
        for (int i = 0; i < cadc_pkg::NCH; i++) begin
          dac_out_reg[i] <= dac_in_reg[i];
        end
      end
      if (load_now) dac_out_reg[dac_ch] <= reg_wdata[11:0];
    end
  end

  for (genvar g = 0; g < cadc_pkg::NCH; g++) begin : g_dac
    assign dac_code_flat[g*12 +: 12] = dac_out_reg[g];
  end

  // Pin functions; DAC takes the pin over a digital output
  wire [7:0] any_func = adc_cfg_reg[7:0] | dac_cfg_reg[7:0]
                        | gpio_ocfg_reg[7:0] | gpio_icfg_reg[7:0];
  assign dac_out_en = dac_cfg_reg[7:0];
  assign adc_in_en = adc_cfg_reg[7:0];
  assign configurable_pin_oe = gpio_ocfg_reg[7:0]
                               & ~dac_cfg_reg[7:0];
  assign configurable_pin_out = gpio_data_reg[7:0];
  assign pulldown_en = pulldn_reg[7:0] & ~any_func;
  assign dac_gain2 = gp_reg[cadc_pkg::GP_DAC_RANGE_BIT];
  assign adc_gain2 = gp_reg[cadc_pkg::GP_ADC_RANGE_BIT];
  assign adc_buf_en = gp_reg[cadc_pkg::GP_ADC_BUF_BIT];
  assign ref_en = pwr_reg[cadc_pkg::PWR_REF_BIT];

  // Pin and serial-link inputs come from outside this clock
  logic [7:0] pin_s1_reg, pin_s2_reg;
  logic scl_s1_reg, scl_s2_reg, scl_d_reg;
  logic sda_s1_reg, sda_s2_reg, sda_d_reg;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_reg <= 8'h00;
      pin_s2_reg <= 8'h00;
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      pin_s1_reg <= configurable_pin_in;
      pin_s2_reg <= pin_s1_reg;
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg <= scl_s2_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg <= sda_s2_reg;
    end
  end

  wire [7:0] gpio_rb = pin_s2_reg & gpio_icfg_reg[7:0];

  // Follow the address byte of each frame to find a read's ack clock
  wire scl_rise = scl_s2_reg && !scl_d_reg;
  wire start_cond = scl_s2_reg && scl_d_reg && sda_d_reg && !sda_s2_reg;
  logic frame_act_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] addr_sh_reg;
  logic conv_trig_reg;
  wire addr_hit = (addr_sh_reg[7:1] == SLAVE_ADDR) && addr_sh_reg[0];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_act_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      addr_sh_reg <= 8'h00;
      conv_trig_reg <= 1'b0;
    end else begin
      conv_trig_reg <= 1'b0;
      if (start_cond) begin
        frame_act_reg <= 1'b1;
        bit_cnt_reg <= 4'h0;
      end else if (frame_act_reg && scl_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        if (bit_cnt_reg == cadc_pkg::ACK_BIT_IDX) begin
          frame_act_reg <= 1'b0;
          conv_trig_reg <= addr_hit;
        end else begin
          addr_sh_reg <= {addr_sh_reg[6:0], sda_s2_reg};
        end
      end
    end
  end

  // ADC sequencer
  cadc_pkg::cadc_seq_state_t state_reg, state_next;
  logic [3:0] cur_ch_reg, first_ch_reg;
  logic [9:0] cnt_reg;
  logic trig_pend_reg, running_reg;
  logic [11:0] res_reg [9];
  logic [8:0] res_valid_reg;
  logic [3:0] rd_ptr_reg;

  wire [8:0] seq_mask = {reg_wdata[cadc_pkg::SEQ_TEMP_BIT],
                         reg_wdata[7:0]};
  wire [8:0] live_mask = {seq_reg[cadc_pkg::SEQ_TEMP_BIT], seq_reg[7:0]};
  wire [4:0] first_sel = next_ch(seq_mask, 4'h0);
  wire [4:0] step_sel = next_ch(live_mask, cur_ch_reg + 4'h1);
  wire is_temp = (cur_ch_reg == cadc_pkg::TEMP_CH);
  wire [9:0] temp_len = adc_buf_en ? TEMP_BUF_N : TEMP_UNBUF_N;
  wire [9:0] conv_len = is_temp ? temp_len : CONV_N;
  wire track_done = (cnt_reg >= TRACK_N);
  wire conv_go = track_done && (running_reg || trig_pend_reg);
  wire conv_end = (state_reg == cadc_pkg::SEQ_CONV)
                  && (cnt_reg == conv_len - 10'h001);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cadc_pkg::SEQ_IDLE: state_next = cadc_pkg::SEQ_IDLE;
      cadc_pkg::SEQ_TRACK: begin
        if (conv_go) state_next = cadc_pkg::SEQ_CONV;
      end
      cadc_pkg::SEQ_CONV: begin
        if (conv_end) state_next = cadc_pkg::SEQ_TRACK;
      end
      default: state_next = cadc_pkg::SEQ_IDLE;
    endcase
    if (wr_seq) begin
      state_next = first_sel[4] ? cadc_pkg::SEQ_TRACK : cadc_pkg::SEQ_IDLE;
    end
    if (soft_rst_reg) state_next = cadc_pkg::SEQ_IDLE;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= cadc_pkg::SEQ_IDLE;
      cur_ch_reg <= 4'h0;
      first_ch_reg <= 4'h0;
      cnt_reg <= 10'h000;
      running_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (soft_rst_reg) begin
        running_reg <= 1'b0;
        cnt_reg <= 10'h000;
      end else if (wr_seq) begin
        cur_ch_reg <= first_sel[3:0];
        first_ch_reg <= first_sel[3:0];
        cnt_reg <= 10'h000;
        running_reg <= 1'b0;
      end else if (state_reg == cadc_pkg::SEQ_TRACK) begin
        cnt_reg <= conv_go ? 10'h000 : (track_done ? cnt_reg
                                        : cnt_reg + 10'h001);
        if (conv_go) running_reg <= 1'b1;
      end else if (state_reg == cadc_pkg::SEQ_CONV) begin
        cnt_reg <= conv_end ? 10'h000 : cnt_reg + 10'h001;
        if (conv_end) begin
          cur_ch_reg <= step_sel[3:0];
          if (step_sel[3:0] == first_ch_reg) running_reg <= 1'b0;
        end
      end
    end
  end

  // A trigger waiting on the track time is held, set beats clear
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      trig_pend_reg <= 1'b0;
    end else if (conv_trig_reg) begin
      trig_pend_reg <= 1'b1;
    end else if (soft_rst_reg || wr_seq
                 || (state_reg == cadc_pkg::SEQ_TRACK && conv_go)) begin
      trig_pend_reg <= 1'b0;
    end
  end

  assign adc_mux_sel = cur_ch_reg;
  assign adc_track = (state_reg == cadc_pkg::SEQ_TRACK);
  assign adc_convert = (state_reg == cadc_pkg::SEQ_CONV);

  // Results wait per channel until read, oldest order from rd_ptr
  wire adc_rb = reg_rd && (op_mode == cadc_pkg::MODE_ADC_RB);
  wire [4:0] rb_sel = next_ch(res_valid_reg, rd_ptr_reg);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      res_valid_reg <= 9'h000;
      rd_ptr_reg <= 4'h0;
      for (int i = 0; i < 9; i++) res_reg[i] <= 12'h000;
    end else if (soft_rst_reg || wr_seq) begin
      res_valid_reg <= 9'h000;
      rd_ptr_reg <= wr_seq ? first_sel[3:0] : 4'h0;
    end else begin
      if (adc_rb && rb_sel[4]) begin
        res_valid_reg[rb_sel[3:0]] <= 1'b0;
        rd_ptr_reg <= (rb_sel[3:0] == cadc_pkg::TEMP_CH) ? 4'h0
                      : rb_sel[3:0] + 4'h1;
      end
      if (conv_end) begin
        res_reg[cur_ch_reg] <= adc_code;
        res_valid_reg[cur_ch_reg] <= 1'b1;
      end
    end
  end

  // Read-back selection
  logic [15:0] cfg_rb, rd_mux;
  always_comb begin
    case (op_idx)
      cadc_pkg::REG_ADC_SEQ: cfg_rb = seq_reg;
      cadc_pkg::REG_GP_CTRL: cfg_rb = gp_reg;
      cadc_pkg::REG_ADC_CFG: cfg_rb = adc_cfg_reg;
      cadc_pkg::REG_DAC_CFG: cfg_rb = dac_cfg_reg;
      cadc_pkg::REG_PULLDN: cfg_rb = pulldn_reg;
      cadc_pkg::REG_DEFER_LOAD: cfg_rb = load_mode_reg;
      cadc_pkg::REG_GPIO_OCFG: cfg_rb = gpio_ocfg_reg;
      cadc_pkg::REG_GPIO_DATA: cfg_rb = gpio_data_reg;
      cadc_pkg::REG_GPIO_ICFG: cfg_rb = gpio_icfg_reg;
      cadc_pkg::REG_PWR_REF: cfg_rb = pwr_reg;
      default: cfg_rb = 16'h0000;
    endcase
    case (op_mode)
      cadc_pkg::MODE_ADC_RB: begin
        rd_mux = rb_sel[4] ? {rb_sel[3:0], res_reg[rb_sel[3:0]]}
                           : 16'h0000;
      end
      cadc_pkg::MODE_DAC_RB: begin
        rd_mux = op_idx[3] ? 16'h0000
                           : {1'b0, dac_ch, dac_out_reg[dac_ch]};
      end
      cadc_pkg::MODE_GPIO_RB: rd_mux = {8'h00, gpio_rb};
      cadc_pkg::MODE_REG_RB: rd_mux = cfg_rb;
      default: rd_mux = 16'h0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

endmodule

// *** verification/cadc_port_ctrl_assertions.sv ***
// Concurrent checks on the port control's pins
`timescale 1ns/100ps
module cadc_port_ctrl_assertions (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [7:0] configurable_pin_out,
  input wire logic [7:0] configurable_pin_oe,
  input wire logic [7:0] pulldown_en,
  input wire logic [7:0] dac_out_en,
  input wire logic [7:0] adc_in_en,
  input wire logic dac_gain2,
  input wire logic adc_gain2,
  input wire logic adc_buf_en,
  input wire logic ref_en,
  input wire logic [3:0] adc_mux_sel,
  input wire logic adc_track,
  input wire logic adc_convert,
  input wire logic reset_busy
);
  logic [9:0] trk_cnt;
  logic [9:0] conv_cnt;
  logic [9:0] conv_lim;
  assign conv_lim = (adc_mux_sel != cadc_pkg::TEMP_CH) ?
    10'(cadc_pkg::CONV_CYC) : adc_buf_en ?
    10'(cadc_pkg::TEMP_BUF_CYC) : 10'(cadc_pkg::TEMP_UNBUF_CYC);
  // Track count saturates so a long wait in track for a trigger cannot wrap it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      trk_cnt <= 10'h000;
      conv_cnt <= 10'h000;
    end else begin
      trk_cnt <= !adc_track ? 10'h000 :
        (trk_cnt == 10'h3FF) ? trk_cnt : trk_cnt + 10'h001;
      conv_cnt <= adc_convert ? conv_cnt + 10'h001 : 10'h000;
    end
  end
  function automatic logic [3:0] first_sel(input logic [8:0] m);
    first_sel = 4'h0;
    for (int i = 8; i >= 0; i--) begin
      if (m[i]) begin
        first_sel = 4'(i);
      end
    end
  endfunction
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence seq_write_s;
    reg_wr && reg_addr == 8'h02 && reg_wdata[8:0] != 9'h000;
  endsequence
  sequence soft_key_s;
    reg_wr && reg_addr == 8'h0F && reg_wdata == cadc_pkg::SW_RESET_KEY;
  endsequence
  sequence defaults_s;
    pulldown_en == 8'hFF && !ref_en && reset_busy && dac_out_en == 8'h00
      && !adc_track && !adc_convert;
  endsequence
  dac_wins_pin_a: assert property (
    (configurable_pin_oe & dac_out_en) == 8'h00) else $error("Pin clash");
  pulldown_free_a: assert property (
    (pulldown_en & (dac_out_en | adc_in_en | configurable_pin_oe)) == 8'h00)
    else $error("Pull-down on used pin");
  reset_defaults_a: assert property ($rose(reset_n) |-> defaults_s)
    else $error("Not default after reset");
  seq_track_a: assert property (seq_write_s |=> adc_track &&
    adc_mux_sel == first_sel($past(reg_wdata[8:0])))
    else $error("First channel not tracking");
  track_time_a: assert property ($rose(adc_convert) |->
    trk_cnt >= 10'(cadc_pkg::TRACK_CYC)) else $error("Track too short");
  conv_time_a: assert property ($fell(adc_convert) |->
    conv_cnt == $past(conv_lim)) else $error("Conversion length wrong");
  gain_write_a: assert property (reg_wr && reg_addr == 8'h03 |=>
    dac_gain2 == $past(reg_wdata[cadc_pkg::GP_DAC_RANGE_BIT]) &&
    adc_gain2 == $past(reg_wdata[cadc_pkg::GP_ADC_RANGE_BIT]))
    else $error("Range bit not applied");
  ref_write_a: assert property (reg_wr && reg_addr == 8'h0B |=>
    ref_en == $past(reg_wdata[cadc_pkg::PWR_REF_BIT]))
    else $error("Reference enable wrong");
  gpio_data_a: assert property (reg_wr && reg_addr == 8'h09 |=>
    configurable_pin_out == $past(reg_wdata[7:0])) else $error("GPIO data");
  soft_reset_a: assert property (soft_key_s |-> ##3 defaults_s)
    else $error("Soft reset missed");
endmodule

bind cadc_port_ctrl cadc_port_ctrl_assertions cadc_port_ctrl_assertions_inst (
  .ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .configurable_pin_out,
  .configurable_pin_oe, .pulldown_en, .dac_out_en, .adc_in_en, .dac_gain2,
  .adc_gain2, .adc_buf_en, .ref_en, .adc_mux_sel, .adc_track, .adc_convert,
  .reset_busy);

// *** verification/cadc_link_master.sv ***
// Two-wire bus master model that frames one address byte
`timescale 1ns/100ps
module cadc_link_master (
  input wire logic go,
  input wire logic [7:0] addr_byte,
  output logic scl,
  output logic sda,
  output logic busy
);
  // Clock stands high between frames; data idles at its pull-up level
  // One process drives the wires so each has a single driver
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge go);
      busy = 1'b1;
      #160 sda = 1'b0;
      #160 scl = 1'b0;
      // Ninth bit released: nothing here pulls it low, pull-up wins
      for (int i = 8; i >= 0; i--) begin
        #80 sda = (i > 0) ? addr_byte[i - 1] : 1'b1;
        #80 scl = 1'b1;
        #160 scl = 1'b0;
      end
      #80 sda = 1'b0;
      #80 scl = 1'b1;
      #160 sda = 1'b1;
      busy = 1'b0;
    end
  end
endmodule

// *** verification/tb_cadc_port_ctrl.sv ***
// Self-checking bench for the configurable port control
`timescale 1ns/100ps
module tb_cadc_port_ctrl;
  logic ref_clk, reset_n, reg_wr, reg_rd, scl_in, sda_in;
  logic link_go, link_busy, dac_gain2, adc_gain2, adc_buf_en, ref_en;
  logic adc_track, adc_convert, reset_busy;
  logic [7:0] reg_addr, link_byte, configurable_pin_in, configurable_pin_out;
  logic [7:0] configurable_pin_oe, pulldown_en, dac_out_en, adc_in_en;
  logic [15:0] reg_wdata, reg_rdata;
  logic [95:0] dac_code_flat;
  logic [11:0] adc_code;
  logic [3:0] adc_mux_sel;
  int n_fail, n_tests;

  cadc_port_ctrl #(.RESET_HOLD_CYC(20)) cadc_port_ctrl_inst (
    .ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .scl_in, .sda_in, .configurable_pin_in,
    .configurable_pin_out, .configurable_pin_oe, .pulldown_en,
    .dac_out_en, .dac_code_flat, .dac_gain2, .adc_in_en, .adc_gain2,
    .adc_buf_en, .ref_en, .adc_mux_sel, .adc_track, .adc_convert,
    .adc_code, .reset_busy);
  cadc_link_master cadc_link_master_inst (.go(link_go),
    .addr_byte(link_byte), .scl(scl_in), .sda(sda_in), .busy(link_busy));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Code carries the channel so each stored result shows where it came from
  always @(posedge ref_clk) adc_code <= {adc_mux_sel, 8'h5A};

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_lvl(ref logic s, input logic lvl, input int lim);
    int n = 0;
    while (s !== lvl) begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > lim) begin
        n_fail++;
        $display("ERROR at %0t: wait got %h expected %h", $time, s, lvl);
        complete_run();
      end
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic send(input logic [7:0] b);
    @(posedge ref_clk);
    link_byte <= b;
    link_go <= 1'b1;
    @(posedge ref_clk);
    link_go <= 1'b0;
    #1;
  endtask

  task automatic t_reset();
    chk({pulldown_en, configurable_pin_oe}, 16'hFF00);
    chk({12'h000, ref_en, adc_track, adc_convert, reset_busy}, 16'h0001);
    rd(8'h76, 16'h00FF);
    wait_lvl(reset_busy, 1'b0, 100);
  endtask
  task automatic t_config();
    wr(8'h04, 16'h0003);
    wr(8'h05, 16'h0001);
    wr(8'h08, 16'h0003);
    wr(8'h09, 16'h00FF);
    wr(8'h0A, 16'h0006);
    chk({dac_out_en, adc_in_en}, 16'h0103);
    chk({configurable_pin_oe, configurable_pin_out}, 16'h02FF);
    chk({pulldown_en, 8'h00}, 16'hF800);
    rd(8'h60, 16'h0002);
  endtask
  task automatic t_lock();
    wr(8'h03, 16'h02B0);
    chk({13'h0000, dac_gain2, adc_gain2, adc_buf_en}, 16'h0007);
    wr(8'h05, 16'h00FF);
    chk({8'h00, dac_out_en}, 16'h0001);
    wr(8'h03, 16'h0200);
    chk({13'h0000, dac_gain2, adc_gain2, adc_buf_en}, 16'h0001);
  endtask
  task automatic t_dac();
    wr(8'h10, 16'h0FFF);
    chk({4'h0, dac_code_flat[11:0]}, 16'h0FFF);
    wr(8'h07, 16'h0001);
    wr(8'h11, 16'h0123);
    chk({4'h0, dac_code_flat[23:12]}, 16'h0000);
    wr(8'h07, 16'h0002);
    chk({4'h0, dac_code_flat[23:12]}, 16'h0123);
    rd(8'h51, 16'h1123);
    wr(8'h0B, 16'h0200);
    chk({15'h0000, ref_en}, 16'h0001);
  endtask
  task automatic t_adc();
    wr(8'h02, 16'h0103);
    chk({11'h000, adc_track, adc_mux_sel}, 16'h0010);
    send(8'h20);
    wait_lvl(link_busy, 1'b0, 200);
    chk({15'h0000, adc_convert}, 16'h0000);
    send(8'h21);
    wait_lvl(adc_convert, 1'b1, 200);
    chk({12'h000, adc_mux_sel}, 16'h0000);
    wait_lvl(adc_convert, 1'b0, 100);
    wait_lvl(adc_convert, 1'b1, 100);
    chk({12'h000, adc_mux_sel}, 16'h0001);
    wait_lvl(adc_convert, 1'b0, 100);
    wait_lvl(adc_convert, 1'b1, 100);
    chk({12'h000, adc_mux_sel}, 16'h0008);
    wait_lvl(adc_convert, 1'b0, 200);
    rd(8'h40, 16'h005A);
    rd(8'h40, 16'h115A);
    rd(8'h40, 16'h885A);
  endtask
  task automatic t_resets();
    wr(8'h0F, 16'h0DAC);
    repeat (3) @(posedge ref_clk);
    #1;
    chk({pulldown_en, dac_out_en}, 16'hFF00);
    chk({14'h0000, ref_en, reset_busy}, 16'h0001);
    wait_lvl(reset_busy, 1'b0, 100);
    rd(8'h73, 16'h0000);
    // Buffer is off after the soft reset: long temperature conversion
    wr(8'h02, 16'h0100);
    send(8'h21);
    wait_lvl(adc_convert, 1'b1, 200);
    chk({12'h000, adc_mux_sel}, 16'h0008);
    wait_lvl(adc_convert, 1'b0, 600);
    rd(8'h40, 16'h885A);
    wr(8'h0B, 16'h0200);
    chk({15'h0000, ref_en}, 16'h0001);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    @(posedge ref_clk);
    reset_n <= 1'b1;
    #1;
    chk({7'h00, ref_en, pulldown_en}, 16'h00FF);
    wait_lvl(reset_busy, 1'b0, 100);
  endtask

  initial begin
    n_fail = 0;
    n_tests = 0;
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    configurable_pin_in = 8'hA3;
    link_go = 1'b0;
    link_byte = 8'h00;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    t_reset();
    t_config();
    t_lock();
    t_dac();
    t_adc();
    t_resets();
    complete_run();
  end
endmodule
